// ==== common/gla_pkg.sv ====
// Package: register indices, field positions, reset values and bus types
package gla_pkg;

  // Register select codes on the processor register port
  localparam logic [2:0] REG_AUX_CMD   = 3'h3;
  localparam logic [2:0] REG_ADDR      = 3'h4;
  localparam logic [2:0] REG_SRQ       = 3'h5;
  localparam logic [2:0] REG_SNOOP_PP  = 3'h6;
  localparam logic [2:0] REG_DATA      = 3'h7;

  // Address register fields
  localparam int ADDR_LO     = 0;
  localparam int ADDR_W      = 5;
  localparam int TALK_DIS    = 5;
  localparam int LISTEN_DIS  = 6;
  localparam int ADJ_EN      = 7;

  // Serial poll register fields
  localparam int RSV_BIT     = 6;

  // Auxiliary command fields
  localparam int AUX_ULPA    = 1;
  localparam int AUX_RFDR    = 6;
  localparam int AUX_RESET   = 7;

  // Address mode fields, held outside this block and given as hold inputs
  localparam int MODE_HOLD_END = 3;
  localparam int MODE_HOLD_ALL = 2;

  // Reset values
  localparam logic [7:0] ADDR_RST   = 8'h00;
  localparam logic [7:0] BYTE_RST   = 8'h00;

  // Address status views
  localparam logic [7:0] ASTAT_LADS = 8'h90;
  localparam logic [7:0] ASTAT_LACS = 8'h04;
  localparam logic [7:0] ASTAT_IDLE = 8'h00;

  // Command group codes: listen group 001xxxxx, talk group 010xxxxx
  localparam logic [2:0] LISTEN_GRP = 3'h1;
  localparam logic [2:0] TALK_GRP   = 3'h2;

  // Processor side register access
  typedef struct packed {
    logic       sel;
    logic       rd_nwr;
    logic [2:0] rs;
    logic [7:0] wdata;
  } gla_cpu_req_t;

  // Bus management and data lines, true = asserted
  typedef struct packed {
    logic       atn;
    logic       eoi;
    logic       dav;
    logic [7:0] dio;
  } gla_bus_in_t;

  typedef enum logic [2:0] {
    LST_IDLE   = 3'b001,
    LST_ADDR   = 3'b010,
    LST_ACTIVE = 3'b100
  } gla_lstate_t;

endpackage

// ==== hw/gla_listener_regs.sv ====
// Address, poll and data registers with primary and dual address listener
`timescale 1ns/100ps
module gla_listener_regs (
  input  wire logic                 clk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 ce_i,
  input  wire gla_pkg::gla_cpu_req_t cpu_i,
  input  wire gla_pkg::gla_bus_in_t bus_i,
  input  wire logic                 spas_i,
  input  wire logic                 all_accepted_i,
  input  wire logic                 hold_on_end_i,
  input  wire logic                 hold_on_all_i,
  output logic [7:0]                rdata_o,
  output logic                      srq_n_o,
  output logic [7:0]                dio_o,
  output logic                      dio_oe_o,
  output logic                      dac_hold_o,
  output logic                      rfd_hold_o,
  output logic                      byte_in_flag_o,
  output logic                      byte_out_flag_o,
  output logic                      end_received_flag_o,
  output logic [7:0]                address_state_view_o,
  output logic                      talker_enable_o,
  output logic                      talk_addressed_o
);
  import gla_pkg::*;

  logic [7:0]  device_address_config;
  logic [7:0]  service_request_status;
  logic        service_request_pending;
  logic [7:0]  parallel_poll_response;
  logic [7:0]  received_byte;
  logic [7:0]  transmit_byte;
  logic        soft_reset;
  logic        ready_release_strobe;
  logic        addr_lsb;
  logic        dav_q;
  logic        read_pending;
  gla_lstate_t lstate;
  gla_lstate_t next_lstate;
  logic [7:0]  next_rdata;

  // Decode
  wire wr        = ce_i && cpu_i.sel && !cpu_i.rd_nwr;
  wire rd        = ce_i && cpu_i.sel &&  cpu_i.rd_nwr;
  wire wr_aux    = wr && cpu_i.rs == REG_AUX_CMD;
  wire wr_addr   = wr && cpu_i.rs == REG_ADDR;
  wire wr_srq    = wr && cpu_i.rs == REG_SRQ && !soft_reset;
  wire wr_pp     = wr && cpu_i.rs == REG_SNOOP_PP && !soft_reset;
  wire wr_dout   = wr && cpu_i.rs == REG_DATA && !soft_reset;
  wire rd_din    = rd && cpu_i.rs == REG_DATA;
  wire dav_rise  = bus_i.dav && !dav_q;

  // Address match; LSB ignored in dual address mode
  wire [4:0] my_addr  = device_address_config[ADDR_LO +: ADDR_W];
  wire [4:0] lsb_mask = {4'hf, !device_address_config[ADJ_EN]};
  wire addr_hit = ((bus_i.dio[4:0] ^ my_addr) & lsb_mask) == 5'h00;
  wire cmd_byte = bus_i.atn && dav_rise;
  wire mla = cmd_byte && bus_i.dio[7:5] == {1'b0, LISTEN_GRP[1:0]}
             && addr_hit && !device_address_config[LISTEN_DIS];
  wire mta = cmd_byte && bus_i.dio[7:5] == {1'b0, TALK_GRP[1:0]}
             && addr_hit && !device_address_config[TALK_DIS];
  wire unl = cmd_byte && bus_i.dio[6:0] == 7'h3f;
  wire data_byte = !bus_i.atn && dav_rise && lstate == LST_ACTIVE;

  // Poll guard: a low write to the request bit is refused during a poll
  wire rsv_new = (spas_i && !cpu_i.wdata[RSV_BIT])
                 ? service_request_status[RSV_BIT]
                 : cpu_i.wdata[RSV_BIT];

  always_comb begin
    next_lstate = lstate;
    case (lstate)
      LST_IDLE:   if (mla) next_lstate = LST_ADDR;
      // Unlisten must also drop an addressed listener, not only an active one
      LST_ADDR: begin
        if (unl) next_lstate = LST_IDLE;
        else if (!bus_i.atn) next_lstate = LST_ACTIVE;
      end
      LST_ACTIVE: if (unl) next_lstate = LST_IDLE;
      default:    next_lstate = LST_IDLE;
    endcase
    if (device_address_config[LISTEN_DIS] || soft_reset) begin
      next_lstate = LST_IDLE;
    end
  end

  assign next_rdata =
    (cpu_i.rs == REG_AUX_CMD)  ? {soft_reset, 5'h00, addr_lsb, 1'b0} :
    (cpu_i.rs == REG_SRQ)      ? {service_request_status[7],
                                  service_request_pending,
                                  service_request_status[5:0]} :
    (cpu_i.rs == REG_SNOOP_PP) ? bus_i.dio :
    (cpu_i.rs == REG_DATA)     ? received_byte : 8'h00;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      device_address_config <= ADDR_RST;
      soft_reset <= 1'b1;
    end else if (ce_i) begin
      if (wr_addr) device_address_config <= cpu_i.wdata;
      if (wr_aux)  soft_reset <= cpu_i.wdata[AUX_RESET];
    end
  end

  // Serial poll and parallel poll registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i || (ce_i && soft_reset)) begin
      service_request_status  <= BYTE_RST;
      service_request_pending <= 1'b0;
      parallel_poll_response  <= BYTE_RST;
    end else if (ce_i) begin
      if (wr_srq) begin
        service_request_status <= {cpu_i.wdata[7], rsv_new,
                                   cpu_i.wdata[5:0]};
      end
      // A fresh request wins over the poll clear in the same cycle
      if (wr_srq && rsv_new && !service_request_status[RSV_BIT])
        service_request_pending <= 1'b1;
      else if (spas_i || (wr_srq && !rsv_new))
        service_request_pending <= 1'b0;
      if (wr_pp) parallel_poll_response <= cpu_i.wdata;
    end
  end

  // Listener, handshake holds and flags
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      lstate               <= LST_IDLE;
      dav_q                <= 1'b0;
      received_byte        <= BYTE_RST;
      transmit_byte        <= BYTE_RST;
      byte_in_flag_o       <= 1'b0;
      byte_out_flag_o      <= 1'b0;
      end_received_flag_o  <= 1'b0;
      dac_hold_o           <= 1'b0;
      rfd_hold_o           <= 1'b0;
      read_pending         <= 1'b0;
      ready_release_strobe <= 1'b0;
      addr_lsb             <= 1'b0;
    end else if (ce_i) begin
      lstate <= next_lstate;
      dav_q  <= bus_i.dav;
      if (mla || mta) addr_lsb <= bus_i.dio[0];
      if (data_byte) begin
        received_byte  <= bus_i.dio;
        dac_hold_o     <= 1'b1;
        byte_in_flag_o <= 1'b1;
        if (hold_on_all_i || (hold_on_end_i && bus_i.eoi))
          rfd_hold_o <= 1'b1;
      end else if (rd_din) begin
        byte_in_flag_o <= 1'b0;
        read_pending   <= 1'b1;
      end
      // Release one cycle later so the read cycle has ended first
      if (read_pending && !data_byte) begin
        dac_hold_o   <= 1'b0;
        read_pending <= 1'b0;
      end
      if (data_byte && bus_i.eoi)
        end_received_flag_o <= 1'b1;
      else if (!bus_i.eoi || bus_i.atn)
        end_received_flag_o <= 1'b0;
      ready_release_strobe <= wr_aux && cpu_i.wdata[AUX_RFDR]
                              && !soft_reset;
      if (ready_release_strobe && !data_byte)
        rfd_hold_o <= 1'b0;
      if (wr_dout) begin
        transmit_byte   <= cpu_i.wdata;
        byte_out_flag_o <= 1'b0;
      end else if (all_accepted_i) begin
        byte_out_flag_o <= 1'b1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o              <= 8'h00;
      srq_n_o              <= 1'b1;
      dio_o                <= 8'h00;
      dio_oe_o             <= 1'b0;
      address_state_view_o <= ASTAT_IDLE;
      talker_enable_o      <= 1'b0;
      talk_addressed_o     <= 1'b0;
    end else if (ce_i) begin
      if (rd) rdata_o <= next_rdata;
      srq_n_o <= !service_request_status[RSV_BIT];
      // Poll response, otherwise outgoing data byte
      if (bus_i.eoi && bus_i.atn) begin
        dio_o    <= parallel_poll_response;
        dio_oe_o <= 1'b1;
      end else begin
        dio_o    <= transmit_byte;
        dio_oe_o <= 1'b0;
      end
      case (next_lstate)
        LST_ADDR:   address_state_view_o <= ASTAT_LADS;
        LST_ACTIVE: address_state_view_o <= ASTAT_LACS;
        default:    address_state_view_o <= ASTAT_IDLE;
      endcase
      talker_enable_o <= !device_address_config[TALK_DIS];
      if (device_address_config[TALK_DIS] || soft_reset)
        talk_addressed_o <= 1'b0;
      else if (mta)
        talk_addressed_o <= 1'b1;
      else if (cmd_byte && bus_i.dio[6:0] == 7'h5f)
        talk_addressed_o <= 1'b0;
    end
  end

endmodule // gla_listener_regs

// ==== bench/gla_listener_regs_assertions.sv ====
// Port-level assertions for the listener register block
`timescale 1ns/100ps
module gla_chk
  import gla_pkg::*;
(
  input wire logic         clk_i,
  input wire logic         nrst_i,
  input wire logic         ce_i,
  input wire gla_cpu_req_t cpu_i,
  input wire gla_bus_in_t  bus_i,
  input wire logic         all_accepted_i,
  input wire logic [7:0]   rdata_o,
  input wire logic         srq_n_o,
  input wire logic         dio_oe_o,
  input wire logic         dac_hold_o,
  input wire logic         rfd_hold_o,
  input wire logic         byte_in_flag_o,
  input wire logic         byte_out_flag_o,
  input wire logic [7:0]   address_state_view_o
);
  wire logic wr = ce_i & cpu_i.sel & ~cpu_i.rd_nwr;
  wire logic rd = ce_i & cpu_i.sel & cpu_i.rd_nwr;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  poll_drive_a: assert property (
    ce_i && bus_i.eoi && bus_i.atn |=> dio_oe_o) else $error("poll idle");
  snoop_live_a: assert property (
    rd && cpu_i.rs == REG_SNOOP_PP |=> rdata_o == $past(bus_i.dio))
    else $error("snoop read stale");
  srq_cause_a: assert property (
    // The request bit is a register of its own, so the pin follows two edges on
    $fell(srq_n_o) |->
    $past(wr && cpu_i.rs == REG_SRQ && cpu_i.wdata[6], 2))
    else $error("srq without request");
  data_read_a: assert property (
    rd && cpu_i.rs == REG_DATA |=> !byte_in_flag_o ##1 !dac_hold_o)
    else $error("data read did not release");
  ready_release_a: assert property (
    wr && cpu_i.rs == REG_AUX_CMD && cpu_i.wdata == 8'h40 |-> ##2 !rfd_hold_o)
    else $error("ready release ignored");
  out_clear_a: assert property (
    wr && cpu_i.rs == REG_DATA |=> !byte_out_flag_o)
    else $error("out flag not cleared");
  out_set_a: assert property (
    $rose(byte_out_flag_o) |-> $past(all_accepted_i))
    else $error("out flag set early");
  listen_active_a: assert property (
    address_state_view_o == ASTAT_LADS && ce_i && !bus_i.atn |=>
    address_state_view_o == ASTAT_LACS) else $error("no active state");
  cover property (dio_oe_o);
  cover property (rfd_hold_o && dac_hold_o);
  cover property (address_state_view_o == ASTAT_LACS);
endmodule // gla_chk
bind gla_listener_regs gla_chk gla_chk_inst (.*);

// ==== bench/gla_bm.sv ====
// Bus partner: controller and talker on the management and data lines
`timescale 1ns/100ps
module gla_bm (
  input  wire logic         clk_i,
  input  wire logic         dac_hold_i,
  output gla_pkg::gla_bus_in_t bus_o,
  output logic              stuck_o
);
  import gla_pkg::*;
  initial begin
    bus_o = '0;
    stuck_o = 1'b0;
  end
  task automatic lines(input logic [1:0] ae, input logic [7:0] d);
    @(posedge clk_i);
    #5 bus_o = {ae, 1'b0, d};
  endtask
  // Data settles for slow cycles before DAV, as a slow talker would
  task automatic xfer(input logic [1:0] ae, input logic [7:0] d,
                      input int slow);
    int n;
    n = 0;
    lines(ae, d);
    repeat (slow) @(posedge clk_i);
    #5 bus_o.dav = 1'b1;
    repeat (2) @(posedge clk_i);
    #5;
    while (dac_hold_i && n < 200) begin
      @(posedge clk_i);
      #5 n++;
    end
    stuck_o = stuck_o | (n == 200);
    bus_o.dav = 1'b0;
    bus_o.eoi = 1'b0;
    // Released lines show the inverse so a stale capture cannot match
    bus_o.dio = ~d;
  endtask
endmodule // gla_bm

// ==== bench/gla_listener_regs_tb.sv ====
// Self-checking bench for the listener register block
`timescale 1ns/100ps
module gla_listener_regs_tb;
  import gla_pkg::*;
  logic         clk_i = 1'b0;
  logic         nrst_i = 1'b0;
  logic         ce_i = 1'b1;
  gla_cpu_req_t cpu_i = '0;
  gla_bus_in_t  bus_i;
  logic         spas_i = 1'b0;
  logic         all_accepted_i = 1'b0;
  logic         hold_on_end_i = 1'b0;
  logic         hold_on_all_i = 1'b0;
  logic [7:0]   rdata_o;
  logic         srq_n_o;
  logic [7:0]   dio_o;
  logic         dio_oe_o;
  logic         dac_hold_o;
  logic         rfd_hold_o;
  logic         byte_in_flag_o;
  logic         byte_out_flag_o;
  logic         end_received_flag_o;
  logic [7:0]   address_state_view_o;
  logic         talker_enable_o;
  logic         talk_addressed_o;
  logic         stuck;
  int           n_fail = 0;
  int           comparisons = 0;
  always #25 clk_i = ~clk_i;
  gla_listener_regs gla_listener_regs_inst (.*);
  gla_bm gla_bm_inst (.clk_i(clk_i), .dac_hold_i(dac_hold_o), .bus_o(bus_i),
    .stuck_o(stuck));
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick;
    @(posedge clk_i);
    #5;
  endtask
  task automatic acc(input logic r, input logic [2:0] s, input logic [7:0] d);
    tick;
    cpu_i = {1'b1, r, s, d};
    tick;
    cpu_i.sel = 1'b0;
    tick;
  endtask
  task automatic held_byte(input logic [1:0] ae, input logic [7:0] d);
    fork
      gla_bm_inst.xfer(ae, d, 2);
      begin
        repeat (5) tick;
        chk(8'(byte_in_flag_o), 8'h1);
        chk(8'(dac_hold_o), 8'h1);
        chk(8'(rfd_hold_o), 8'h1);
        chk(8'(end_received_flag_o), 8'(ae[0]));
        acc(1'b1, REG_SNOOP_PP, 8'h00);
        chk(rdata_o, d);
        chk(8'(dac_hold_o), 8'h1);
        chk(8'(byte_in_flag_o), 8'h1);
        acc(1'b1, REG_DATA, 8'h00);
        chk(rdata_o, d);
        chk(8'(byte_in_flag_o), 8'h0);
        tick;
        chk(8'(dac_hold_o), 8'h0);
        tick;
        chk(8'(end_received_flag_o), 8'h0);
        acc(1'b0, REG_AUX_CMD, 8'h40);
        tick;
        chk(8'(rfd_hold_o), 8'h0);
      end
    join
    chk(8'(stuck), 8'h0);
  endtask
  task automatic t_listen;
    acc(1'b0, REG_AUX_CMD, 8'h00);
    gla_bm_inst.xfer(2'h2, 8'h20, 0);
    chk(address_state_view_o, ASTAT_LADS);
    gla_bm_inst.xfer(2'h2, 8'h3f, 0);
    acc(1'b0, REG_ADDR, 8'h05);
    gla_bm_inst.xfer(2'h2, 8'h24, 0);
    chk(address_state_view_o, ASTAT_IDLE);
    gla_bm_inst.xfer(2'h2, 8'h25, 1);
    chk(address_state_view_o, ASTAT_LADS);
    gla_bm_inst.lines(2'h0, 8'h00);
    repeat (2) tick;
    chk(address_state_view_o, ASTAT_LACS);
    hold_on_all_i = 1'b1;
    held_byte(2'h0, 8'ha5);
    hold_on_all_i = 1'b0;
    hold_on_end_i = 1'b1;
    held_byte(2'h1, 8'h3c);
    hold_on_end_i = 1'b0;
    $display("listen done");
  endtask
  task automatic t_addr_modes;
    acc(1'b0, REG_ADDR, 8'h84);
    for (int i = 0; i < 2; i++) begin
      gla_bm_inst.xfer(2'h2, 8'h3f, 0);
      gla_bm_inst.xfer(2'h2, 8'h24 | 8'(i), 0);
      chk(address_state_view_o, ASTAT_LADS);
      acc(1'b1, REG_AUX_CMD, 8'h00);
      chk(rdata_o & 8'h02, 8'(i) << 1);
    end
    acc(1'b0, REG_ADDR, 8'h65);
    chk(8'(talker_enable_o), 8'h0);
    gla_bm_inst.xfer(2'h2, 8'h3f, 0);
    gla_bm_inst.xfer(2'h2, 8'h25, 0);
    gla_bm_inst.xfer(2'h2, 8'h45, 0);
    chk(address_state_view_o, ASTAT_IDLE);
    chk(8'(talk_addressed_o), 8'h0);
    acc(1'b0, REG_ADDR, 8'h05);
    gla_bm_inst.xfer(2'h2, 8'h45, 0);
    chk(8'(talk_addressed_o), 8'h1);
    $display("address modes done");
  endtask
  task automatic t_polls;
    acc(1'b0, REG_SRQ, 8'hc3);
    chk(8'(srq_n_o), 8'h0);
    acc(1'b1, REG_SRQ, 8'h00);
    chk(rdata_o, 8'hc3);
    spas_i = 1'b1;
    acc(1'b0, REG_SRQ, 8'h83);
    chk(8'(srq_n_o), 8'h0);
    acc(1'b1, REG_SRQ, 8'h00);
    chk(rdata_o & 8'h40, 8'h00);
    spas_i = 1'b0;
    acc(1'b0, REG_SRQ, 8'h03);
    chk(8'(srq_n_o), 8'h1);
    acc(1'b0, REG_SNOOP_PP, 8'h81);
    gla_bm_inst.lines(2'h3, 8'h00);
    repeat (2) tick;
    chk(8'(dio_oe_o), 8'h1);
    chk(dio_o, 8'h81);
    acc(1'b0, REG_SNOOP_PP, 8'h00);
    chk(dio_o, 8'h00);
    acc(1'b0, REG_SNOOP_PP, 8'h81);
    chk(dio_o, 8'h81);
    acc(1'b0, REG_AUX_CMD, 8'h80);
    tick;
    chk(dio_o, 8'h00);
    acc(1'b0, REG_AUX_CMD, 8'h00);
    // A write while the clock enable is low must leave no trace
    ce_i = 1'b0;
    acc(1'b0, REG_SRQ, 8'h40);
    ce_i = 1'b1;
    acc(1'b1, REG_SRQ, 8'h00);
    chk(rdata_o, 8'h00);
    chk(8'(srq_n_o), 8'h1);
    all_accepted_i = 1'b1;
    tick;
    all_accepted_i = 1'b0;
    tick;
    chk(8'(byte_out_flag_o), 8'h1);
    acc(1'b0, REG_DATA, 8'h5a);
    chk(8'(byte_out_flag_o), 8'h0);
    all_accepted_i = 1'b1;
    tick;
    all_accepted_i = 1'b0;
    tick;
    chk(8'(byte_out_flag_o), 8'h1);
    $display("polls done");
  endtask
  task automatic give_verdict;
    $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    #5 nrst_i = 1'b1;
    t_listen;
    t_addr_modes;
    t_polls;
    give_verdict;
  end
endmodule // gla_listener_regs_tb
